/* csau_pkg.sv */
// Purpose: Shared constants of the charger status and alert unit
// Assumes: 20 MHz system clock
// Notes: Register offsets are sub-addresses of the serial port
package csau_pkg;

  // Register sub-addresses
  localparam logic [7:0] ADDR_STATE_FLAGS = 8'h34;
  localparam logic [7:0] ADDR_LOOP_STATUS = 8'h35;
  localparam logic [7:0] ADDR_LIMIT_ALERTS = 8'h36;
  localparam logic [7:0] ADDR_STATE_ALERTS = 8'h37;

  // Register widths
  localparam int STATE_W = 11;
  localparam int LOOP_W = 4;
  localparam int LIMIT_W = 16;
  localparam int PHASE_W = 6;

  // Charger state flag positions
  localparam int BIT_TIMER_TERM = 4;
  localparam int BIT_LOWCUR_TERM = 3;
  localparam int BIT_CHG_TIME_FAULT = 2;
  localparam int BIT_BAT_MISSING = 1;
  localparam int BIT_BAT_SHORT = 0;
  localparam int BIT_PHASE_LSB = 5;

  // Limit alert positions
  localparam int BIT_MEAS_VALID = 15;
  localparam int BIT_LIMIT_UNUSED = 14;
  localparam logic [15:0] LIMIT_WRITABLE = 16'hbfff;

  // Reset values
  localparam logic [10:0] STATE_RST = 11'h000;
  localparam logic [3:0] LOOP_RST = 4'h0;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [10:0] SALERT_RST = 11'h000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MEAS_CYCLE_US = 6500;
  localparam int WARMUP_US = 12000;
  localparam int MEAS_CYCLE_CLKS = (MEAS_CYCLE_US * 1000) / CLK_PERIOD_NS;
  localparam int WARMUP_CLKS = (WARMUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Alert pin states
  typedef enum logic {ALERT_IDLE, ALERT_PULL} csau_alert_state_t;

endpackage

/* csau_alert_unit.sv */
// Purpose: Charger state flags, loop status, latched alerts and alert pin
// Assumes: Condition inputs come from logic on the same clock
`timescale 1ns/1ps

module csau_alert_unit #(
  parameter int MEAS_CYCLES = csau_pkg::MEAS_CYCLE_CLKS,
  parameter int WARMUP_CYCLES = csau_pkg::WARMUP_CLKS
) (
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Charger conditions
  input wire logic CHEM_LITHIUM_I,
  input wire logic CV_TIME_OVER_I,
  input wire logic LOW_CURRENT_I,
  input wire logic CHARGE_TIME_OVER_I,
  input wire logic BAT_MISSING_I,
  input wire logic BAT_SHORT_I,
  input wire logic [5:0] PHASE_REQ_I,
  input wire logic [3:0] LOOP_REQ_I,
  // Limit comparisons and enables
  input wire logic [15:0] LIMIT_COND_I,
  input wire logic [15:0] LIMIT_EN_I,
  input wire logic [10:0] STATE_EN_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Alert response and open-drain alert pin
  input wire logic RESP_READ_DONE_I,
  input wire logic ALERT_I,
  output logic ALERT_O,
  output logic ALERT_OE_O,
  output logic ALERT_LINE_LOW_O,
  // Status
  output logic [10:0] CHG_STATE_O,
  output logic [3:0] LOOP_STATUS_O,
  output logic MEAS_VALID_O
);

  localparam int MC_W = $clog2(MEAS_CYCLES + 1);
  localparam int WU_W = $clog2(WARMUP_CYCLES + 1);
  localparam logic [MC_W-1:0] MC_LAST = MC_W'(MEAS_CYCLES - 1);
  localparam logic [WU_W-1:0] WU_DONE = WU_W'(WARMUP_CYCLES);
  localparam logic [MC_W-1:0] MC_ONE = MC_W'(1);
  localparam logic [WU_W-1:0] WU_ONE = WU_W'(1);

  // Charger state and regulation loop
  logic [10:0] state_raw;
  logic [10:0] state_reg;
  logic [10:0] state_next;
  logic [3:0] loop_reg;
  logic [3:0] loop_next;

  // Limit alerts
  logic [15:0] limit_reg;
  logic [15:0] limit_next;
  logic [15:0] limit_set;
  logic [15:0] limit_clr;
  logic [15:0] snap_reg;
  logic [15:0] cond_now;
  logic wr_limit;

  // Charger state alerts
  logic [10:0] salert_reg;
  logic [10:0] salert_next;
  logic [10:0] salert_set;
  logic [10:0] salert_clr;
  logic wr_salert;

  // Measurement timing
  logic [MC_W-1:0] meas_cnt_reg;
  logic [WU_W-1:0] warm_cnt_reg;
  logic meas_tick;
  logic meas_valid_reg;

  // Alert line
  logic new_alert;
  csau_pkg::csau_alert_state_t alert_state_reg;
  csau_pkg::csau_alert_state_t alert_state_next;
  logic alert_out_reg;
  logic alert_oe_reg;
  logic alert_sync1_reg;
  logic alert_sync2_reg;
  logic line_low_reg;

  // Register read port
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;
  logic rvalid_reg;

  // Measurement cycle timer; the tick marks the end of each cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      meas_cnt_reg <= '0;
    end else if (CE_I) begin
      if (meas_tick) begin
        meas_cnt_reg <= '0;
      end else begin
        meas_cnt_reg <= meas_cnt_reg + MC_ONE;
      end
    end
  end

  assign meas_tick = (meas_cnt_reg == MC_LAST);

  // Warm-up timer; results count as valid once it has run out
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      warm_cnt_reg <= '0;
      meas_valid_reg <= 1'b0;
    end else if (CE_I) begin
      if (warm_cnt_reg != WU_DONE) begin
        warm_cnt_reg <= warm_cnt_reg + WU_ONE;
      end
      meas_valid_reg <= (warm_cnt_reg == WU_DONE);
    end
  end

  // Comparison results are taken only at the end of a measurement cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      snap_reg <= csau_pkg::LIMIT_RST;
    end else if (CE_I && meas_tick) begin
      snap_reg <= LIMIT_COND_I;
    end
  end

  // Alerting conditions, one per limit alert bit
  always_comb begin
    cond_now = csau_pkg::LIMIT_RST;
    cond_now[csau_pkg::BIT_MEAS_VALID] = meas_valid_reg;
    cond_now[13:12] = snap_reg[13:12];
    cond_now[11:10] = snap_reg[11:10];
    cond_now[9:8] = snap_reg[9:8];
    cond_now[7:6] = snap_reg[7:6];
    cond_now[5:4] = snap_reg[5:4];
    cond_now[3:2] = snap_reg[3:2];
    cond_now[1:0] = snap_reg[1:0];
    cond_now[csau_pkg::BIT_LIMIT_UNUSED] = 1'b0;
  end

  // Host writes of zero clear; bit 14 has no latch
  assign wr_limit = REG_WR_I && (REG_ADDR_I == csau_pkg::ADDR_LIMIT_ALERTS);
  assign limit_clr = wr_limit ? (~REG_WDATA_I & csau_pkg::LIMIT_WRITABLE) : 16'h0000;

  // Per-bit latch; a set in the clearing cycle wins, so a live condition re-raises
  for (genvar gi = 0; gi < csau_pkg::LIMIT_W; gi++) begin : g_limit
    assign limit_set[gi] = cond_now[gi] & LIMIT_EN_I[gi];
    assign limit_next[gi] = limit_set[gi] |
      (limit_reg[gi] & ~limit_clr[gi] & LIMIT_EN_I[gi]);
  end

  // Only bits that can latch are stored
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      limit_reg <= csau_pkg::LIMIT_RST;
    end else if (CE_I) begin
      limit_reg <= limit_next & csau_pkg::LIMIT_WRITABLE;
    end
  end

  // Charger state requests; terminations and timer fault need lithium
  always_comb begin
    state_raw = csau_pkg::STATE_RST;
    state_raw[csau_pkg::BIT_PHASE_LSB +: csau_pkg::PHASE_W] = PHASE_REQ_I;
    state_raw[csau_pkg::BIT_TIMER_TERM] = CHEM_LITHIUM_I & CV_TIME_OVER_I;
    state_raw[csau_pkg::BIT_LOWCUR_TERM] = CHEM_LITHIUM_I & LOW_CURRENT_I;
    state_raw[csau_pkg::BIT_CHG_TIME_FAULT] = CHEM_LITHIUM_I & CHARGE_TIME_OVER_I;
    state_raw[csau_pkg::BIT_BAT_MISSING] = BAT_MISSING_I;
    state_raw[csau_pkg::BIT_BAT_SHORT] = BAT_SHORT_I;
  end

  // Flags are exclusive: the lowest request wins, so faults outrank phases
  assign state_next = state_raw & (~state_raw + 11'h001);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_reg <= csau_pkg::STATE_RST;
    end else if (CE_I) begin
      state_reg <= state_next;
    end
  end

  // Only one loop may be shown; the lowest request wins
  assign loop_next = LOOP_REQ_I & (~LOOP_REQ_I + 4'h1);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      loop_reg <= csau_pkg::LOOP_RST;
    end else if (CE_I) begin
      loop_reg <= loop_next;
    end
  end

  // State alerts latch on entry into a state, never for staying in it
  assign wr_salert = REG_WR_I && (REG_ADDR_I == csau_pkg::ADDR_STATE_ALERTS);
  assign salert_clr = wr_salert ? ~REG_WDATA_I[csau_pkg::STATE_W-1:0] : 11'h000;
  assign salert_set = state_next & ~state_reg & STATE_EN_I;
  assign salert_next = salert_set | (salert_reg & ~salert_clr & STATE_EN_I);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      salert_reg <= csau_pkg::SALERT_RST;
    end else if (CE_I) begin
      salert_reg <= salert_next;
    end
  end

  // A set landing on an empty or just-cleared latch is a new alert
  assign new_alert = (|(limit_set & (~limit_reg | limit_clr))) ||
    (|(salert_set & (~salert_reg | salert_clr)));

  // Line stays pulled until the alert response read completes
  always_comb begin
    alert_state_next = alert_state_reg;
    case (alert_state_reg)
      csau_pkg::ALERT_IDLE: begin
        if (new_alert) begin
          alert_state_next = csau_pkg::ALERT_PULL;
        end
      end
      csau_pkg::ALERT_PULL: begin
        if (RESP_READ_DONE_I && !new_alert) begin
          alert_state_next = csau_pkg::ALERT_IDLE;
        end
      end
      default: begin
        alert_state_next = csau_pkg::ALERT_IDLE;
      end
    endcase
  end

  // Open-drain pin: driven low while pulling, released otherwise
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      alert_state_reg <= csau_pkg::ALERT_IDLE;
      alert_oe_reg <= 1'b0;
      alert_out_reg <= 1'b1;
    end else if (CE_I) begin
      alert_state_reg <= alert_state_next;
      alert_oe_reg <= (alert_state_next == csau_pkg::ALERT_PULL);
      alert_out_reg <= (alert_state_next != csau_pkg::ALERT_PULL);
    end
  end

  // Pin level is resynchronised; idle level is high so reset gives no false low
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      alert_sync1_reg <= 1'b1;
      alert_sync2_reg <= 1'b1;
    end else if (CE_I) begin
      alert_sync1_reg <= ALERT_I;
      alert_sync2_reg <= alert_sync1_reg;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      line_low_reg <= 1'b0;
    end else if (CE_I) begin
      line_low_reg <= ~alert_sync2_reg;
    end
  end

  // Read multiplexer
  always_comb begin
    rdata_next = csau_pkg::RDATA_RST;
    case (REG_ADDR_I)
      csau_pkg::ADDR_STATE_FLAGS: begin
        rdata_next = {5'h00, state_reg};
      end
      csau_pkg::ADDR_LOOP_STATUS: begin
        rdata_next = {12'h000, loop_reg};
      end
      csau_pkg::ADDR_LIMIT_ALERTS: begin
        rdata_next = limit_reg & csau_pkg::LIMIT_WRITABLE;
      end
      csau_pkg::ADDR_STATE_ALERTS: begin
        rdata_next = {5'h00, salert_reg};
      end
      default: begin
        rdata_next = csau_pkg::RDATA_RST;
      end
    endcase
  end

  // Read data stands with its valid strobe for one cycle after the request
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_reg <= csau_pkg::RDATA_RST;
      rvalid_reg <= 1'b0;
    end else if (CE_I) begin
      rvalid_reg <= REG_RD_I;
      if (REG_RD_I) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Outputs
  assign REG_RDATA_O = rdata_reg;
  assign REG_RVALID_O = rvalid_reg;
  assign ALERT_O = alert_out_reg;
  assign ALERT_OE_O = alert_oe_reg;
  assign ALERT_LINE_LOW_O = line_low_reg;
  assign CHG_STATE_O = state_reg;
  assign LOOP_STATUS_O = loop_reg;
  assign MEAS_VALID_O = meas_valid_reg;

  // Checks
  AST_TERM_LITHIUM_ONLY: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I && !CHEM_LITHIUM_I |=>
      (state_reg[csau_pkg::BIT_TIMER_TERM:csau_pkg::BIT_CHG_TIME_FAULT] == 3'h0)
  ) else $error("termination flag set without lithium chemistry");

  AST_STATE_EXCLUSIVE: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    $onehot0(state_reg)
  ) else $error("more than one charger state flag set");

  AST_LOOP_EXCLUSIVE: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    $onehot0(loop_reg)
  ) else $error("more than one regulation loop flag set");

  AST_SNAP_STEADY: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !(CE_I && meas_tick) |=> $stable(snap_reg)
  ) else $error("limit comparison taken outside a cycle end");

  AST_LIMIT_GATED: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I |=> ((limit_reg & ~$past(LIMIT_EN_I)) == 16'h0000)
  ) else $error("limit alert set while disabled");

  AST_LIMIT_REARM: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I |=> ((limit_reg & $past(limit_set)) == $past(limit_set))
  ) else $error("enabled live condition not latched");

  AST_PULL_ON_NEW: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I && new_alert |=> (alert_state_reg == csau_pkg::ALERT_PULL) && alert_oe_reg
  ) else $error("new alert did not pull the line");

  AST_PULL_HOLD: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I && alert_oe_reg && !RESP_READ_DONE_I |=> alert_oe_reg
  ) else $error("line released before response read");

  AST_VALID_FIRST: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !meas_valid_reg |-> !limit_reg[csau_pkg::BIT_MEAS_VALID]
  ) else $error("measurement valid alert before warm-up end");

  AST_SALERT_ENTRY: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    CE_I |=> ((salert_reg & ~$past(salert_reg) & ~$past(salert_set)) == 11'h000)
  ) else $error("state alert set without entry");

  AST_UNUSED_ZERO: assert property (
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !limit_reg[csau_pkg::BIT_LIMIT_UNUSED]
  ) else $error("unassigned limit alert bit set");
endmodule

/* csau_host_model.sv */
// Purpose: Host that services the alert line
// Assumes: Line level seen as active-high low flag
// Notes: Completes the alert response read a few cycles later
`timescale 1ns/1ps
module csau_host_model (
  // Clock, reset, line
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_low_i,
  output logic resp_done_o
);
  logic [2:0] wait_reg;
  always_ff @(posedge clk_i) begin
    wait_reg <= (rst_i || !line_low_i || resp_done_o) ? 3'h0 : wait_reg + 3'h1;
    resp_done_o <= !rst_i && line_low_i && (wait_reg == 3'h5);
  end
endmodule

/* test_charger_status_alert_unit.sv */
// Purpose: Self-checking bench of the alert unit
// Assumes: Short measurement and warm-up counts
// Notes: Random conditions come from an LFSR
`timescale 1ns/1ps
module test_charger_status_alert_unit;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] cond = 16'h0000;
  logic [15:0] en = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [15:0] lf = 16'd6337;
  logic [15:0] rdata, d, e;
  logic [10:0] sen = 11'h000;
  logic seen_pull = 1'b0;
  logic rvalid, a_o, a_oe, low, resp_done, mv;
  int num_errors = 0;
  int total_checks = 0;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] expf(input logic [15:0] c, input logic [15:0] m);
    return c & m & csau_pkg::LIMIT_WRITABLE;
  endfunction
  initial forever #25 clk = ~clk;
  always @(posedge clk) lf <= nxt(lf);
  always @(posedge clk) if (a_oe) seen_pull <= 1'b1;
  csau_alert_unit #(.MEAS_CYCLES(8), .WARMUP_CYCLES(16)) dut_u (.CLK_SYS_I(clk), .RST_I(rst),
    .CE_I(1'b1), .CHEM_LITHIUM_I(lf[0]), .CV_TIME_OVER_I(lf[1]), .LOW_CURRENT_I(lf[2]),
    .CHARGE_TIME_OVER_I(lf[3]), .BAT_MISSING_I(lf[4]), .BAT_SHORT_I(lf[5]),
    .PHASE_REQ_I(lf[11:6]), .LOOP_REQ_I(4'h1 << lf[13:12]), .LIMIT_COND_I(cond),
    .LIMIT_EN_I(en), .STATE_EN_I(sen), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .RESP_READ_DONE_I(resp_done), .ALERT_I(a_oe ? a_o : 1'b1), .ALERT_O(a_o),
    .ALERT_OE_O(a_oe), .ALERT_LINE_LOW_O(low), .CHG_STATE_O(), .LOOP_STATUS_O(),
    .MEAS_VALID_O(mv));
  csau_host_model host_u (.clk_i(clk), .rst_i(rst), .line_low_i(low), .resp_done_o(resp_done));
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic x, input logic g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s exp %b got %b", n, x, g);
    end
  endtask
  task automatic wrw(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    while (rvalid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    d = rdata;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cond <= lf;
      en <= (lf ^ 16'h5a5a) & 16'h7fff;
      sen <= lf[10:0];
      repeat (20) @(posedge clk);
      e = expf(cond, en);
      rdr(csau_pkg::ADDR_LIMIT_ALERTS);
      chk("limit_set", e, d);
      wrw(csau_pkg::ADDR_LIMIT_ALERTS, ~e);
      rdr(csau_pkg::ADDR_LIMIT_ALERTS);
      chk("limit_rearm", e, d);
      cond <= 16'h0000;
      repeat (20) @(posedge clk);
      rdr(csau_pkg::ADDR_LIMIT_ALERTS);
      chk("limit_hold", e, d);
      wrw(csau_pkg::ADDR_LIMIT_ALERTS, ~e);
      rdr(csau_pkg::ADDR_LIMIT_ALERTS);
      chk("limit_clear", 16'h0000, d);
      rdr(csau_pkg::ADDR_STATE_ALERTS);
      chk("state_alert_enabled", 16'h0000, d & ~{5'h00, sen});
      rdr(csau_pkg::ADDR_STATE_FLAGS);
      chk_pin("state_single", 1'b1, $onehot0(d));
      rdr(csau_pkg::ADDR_LOOP_STATUS);
      chk_pin("loop_single", 1'b1, $onehot0(d));
    end
    en <= 16'h0000;
    sen <= 11'h000;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk_pin("meas_valid", 1'b1, mv);
    chk_pin("alert_pulled", 1'b1, seen_pull);
    chk_pin("alert_released", 1'b0, a_oe);
    test_done;
  end
endmodule
